// ### core/usart_tx_pkg.sv
// Purpose: Shared constants and types for the serial clock, frame and transmit block
// Assumes: 20 MHz system clock; registers reach the block as plain ports
// Notes:   Operation
// Operation
// R01 - Four clock modes: async normal, async double, sync master, sync slave
// R02 - Async normal bit rate is clock over 16 times divisor plus one
// R03 - Async double speed bit rate is clock over 8 times divisor plus one
// R04 - Master serial clock is system clock over 2 times divisor plus one
// R05 - Master select drives clock pin out or takes it in; pin used only synchronously
// R06 - External clock passes a synchroniser and edge detector, two clocks late
// R07 - Peer keeps external serial clock at or below 1 MHz
// R08 - Data changes on one clock edge, sampled on other; polarity zero changes rising
// R09 - Frame: low start, 5 to 9 data, optional parity, one or two stops
// R10 - Data goes LSB first; parity sits between last data bit and first stop
// R11 - Line idles high; new frame may follow last stop bit directly
// R12 - Size, parity mode and stop count fields set the shared frame format
// R13 - Parity is XOR of data bits, inverted for odd parity
// R14 - Upper parity mode bit inserts parity after MSB before first stop
// R15 - Transmit enable clear takes effect after ongoing frame; pin then released
// R16 - Data write loads buffer; moves to shifter when idle or after last stop
// R17 - Software writes ninth bit before writing low eight bits
// R18 - Buffer empty flag set when empty, cleared by data or by writing zero
// R19 - Buffer empty interrupt requested while flag and enables are set
// R20 - Complete flag set when frame fully shifted and buffer holds nothing
// R21 - Complete flag cleared by interrupt acknowledge or by writing zero
// R22 - Complete interrupt requested while flag and enables are set
// R23 - Mode field value three selects SPI; others async, sync or I2C
// R24 - Size field all ones selects nine-bit characters with separate ninth bit
// R25 - Baud counter reloads from divisor, ticks every divisor plus one clocks
package usart_tx_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned EXT_SCK_MAX_HZ  = 1_000_000;
  // Least external clock period, in system clocks, that the slave path can follow
  localparam int unsigned EXT_SCK_MIN_CYC = CLK_HZ / EXT_SCK_MAX_HZ;

  localparam int unsigned BAUD_DIV_W    = 8;
  localparam int unsigned TX_FIFO_DEPTH = 4;
  localparam int unsigned OS_NORMAL     = 16;
  localparam int unsigned OS_DOUBLE     = 8;
  localparam logic [3:0]  OS_NORMAL_LAST = 4'(OS_NORMAL - 1);
  localparam logic [3:0]  OS_DOUBLE_LAST = 4'(OS_DOUBLE - 1);

  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_I2C   = 2'h2;
  localparam logic [1:0] MODE_SPI   = 2'h3;

  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_9 = 3'h7;

  localparam int unsigned PARITY_ENABLE_POS = 1;
  localparam int unsigned PARITY_ODD_POS    = 0;

  localparam logic RESET_BUFFER_EMPTY = 1'b1;
  localparam logic RESET_COMPLETE     = 1'b0;
  localparam logic LINE_IDLE          = 1'b1;
  localparam logic LINE_START         = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_DATA   = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP1  = 3'h6,
    ST_STOP2  = 3'h7
  } tx_state_t;

  typedef struct packed {
    logic [2:0] character_size_field;
    logic [1:0] parity_mode_field;
    logic       stop_bit_count;
  } frame_format_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] low;
  } tx_word_t;

  function automatic logic [3:0] char_bits(input logic [2:0] size);
    unique case (size)
      SIZE_5:  char_bits = 4'h5;
      SIZE_6:  char_bits = 4'h6;
      SIZE_7:  char_bits = 4'h7;
      SIZE_9:  char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic frame_parity(input tx_word_t w, input logic [2:0] size,
                                        input logic odd);
    logic [8:0] mask;
    mask = 9'h1FF >> (4'h9 - char_bits(size));
    frame_parity = (^(w & mask)) ^ odd;
  endfunction

endpackage

// ### core/word_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two; in_ready comes from a flop
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     in_valid,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          in_ready,
  output logic                          out_valid,
  output logic [WIDTH-1:0]              out_data,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("word_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             full_q;
  logic             push;
  logic             pop;

  assign push      = in_valid & ~full_q;
  assign pop       = out_valid & out_ready;
  assign in_ready  = ~full_q;
  assign out_valid = count_q != '0;
  assign out_data  = mem_q[rd_q];
  assign level     = count_q;
  assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      full_q  <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_d;
      full_q  <= count_d == (AW+1)'(DEPTH);
    end
  end
endmodule // word_fifo

// ### core/usart_clock_frame_transmitter.sv
// Purpose: Baud and serial clock generation, frame building and transmit path
// Assumes: Control fields are stable while a frame is being sent
// Notes:   Frame format is captured at load so a mid-frame change cannot tear it
`timescale 1ns/1ps
module usart_clock_frame_transmitter
  import usart_tx_pkg::*;
#(
  parameter int unsigned BD_W       = BAUD_DIV_W,
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [1:0]      operating_mode_select,
  input  wire logic            double_speed_enable,
  input  wire logic            clock_master_select,
  input  wire logic            clock_polarity,
  input  wire logic [BD_W-1:0] baud_divisor,
  input  wire frame_format_t   frame_format,
  input  wire logic            transmit_enable,
  input  wire logic            transmit_ninth_bit,
  input  wire logic [7:0]      serial_data_register,
  input  wire logic            data_write,
  output logic                 data_write_ready,
  input  wire logic            buffer_empty_clear,
  input  wire logic            transmit_complete_clear,
  input  wire logic            transmit_complete_ack,
  input  wire logic            buffer_empty_irq_enable,
  input  wire logic            transmit_complete_irq_enable,
  input  wire logic            global_irq_enable,
  input  wire logic            serial_clock_pin_in,
  output logic                 serial_clock_pin_out,
  output logic                 serial_clock_pin_oe,
  output logic                 serial_output_pin,
  output logic                 serial_output_pin_oe,
  output logic                 buffer_empty_flag,
  output logic                 transmit_complete_flag,
  output logic                 buffer_empty_irq,
  output logic                 transmit_complete_irq
);
  if (BD_W < 1 || BD_W > 16) begin : g_bd_chk
    $error("baud divisor width must be 1 to 16");
  end

  tx_state_t                    tx_state_q;
  tx_word_t                     fifo_word;
  logic                         fifo_out_valid;
  logic                         fifo_out_ready;
  logic [$clog2(FIFO_DEPTH):0]  fifo_level;
  logic                         push;
  logic                         load;
  logic                         busy;
  logic                         sync_mode;
  logic                         master;
  logic                         last_stop;
  logic                         bit_end;

  // Mode decode
  assign sync_mode = operating_mode_select == MODE_SYNC ||
                     operating_mode_select == MODE_SPI; // R01 R23
  assign master    = sync_mode & clock_master_select; // R05
  assign busy      = tx_state_q != ST_IDLE;

  // Transmit buffer
  assign push = data_write & data_write_ready;

  word_fifo #(
    .WIDTH ($bits(tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (data_write),
    .in_data   ({transmit_ninth_bit, serial_data_register}),
    .in_ready  (data_write_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_word),
    .out_ready (fifo_out_ready),
    .level     (fifo_level)
  );

  // External clock path: s1 feeds only s2; s2/s3 form the edge detector
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_s3_q;
  logic ext_change;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= serial_clock_pin_in; // R06
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  assign ext_change = clock_polarity ? (sck_s3_q & ~sck_s2_q)
                                     : (sck_s2_q & ~sck_s3_q); // R08

  // Baud counter; restarted at load so the first bit is full length in the async modes
  logic [BD_W-1:0] baud_cnt_q;
  logic            baud_tick;

  assign baud_tick = baud_cnt_q == '0; // R25

  always_ff @(posedge clk) begin
    if (reset) begin
      baud_cnt_q <= '0;
    end else if (load || baud_tick) begin
      baud_cnt_q <= baud_divisor; // R25
    end else begin
      baud_cnt_q <= baud_cnt_q - 1'b1;
    end
  end

  // Oversampling stage for asynchronous bit timing
  logic [3:0] os_q;
  logic [3:0] os_last;
  logic       async_end;

  assign os_last   = double_speed_enable ? OS_DOUBLE_LAST : OS_NORMAL_LAST; // R02 R03
  assign async_end = baud_tick && os_q == os_last;

  always_ff @(posedge clk) begin
    if (reset || load) begin
      os_q <= '0;
    end else if (baud_tick) begin
      os_q <= async_end ? 4'h0 : os_q + 4'h1;
    end
  end

  // Master serial clock toggles each baud tick while a frame runs
  logic sck_q;
  logic master_change;

  assign master_change = baud_tick && busy && sck_q == clock_polarity; // R08

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_q <= 1'b0;
    end else if (!busy || !master) begin
      sck_q <= clock_polarity;
    end else if (baud_tick) begin
      sck_q <= ~sck_q; // R04
    end
  end

  assign bit_end = !sync_mode ? async_end :
                   master     ? master_change : ext_change; // R01

  // Frame sequencing
  logic [8:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic       par_en_q;
  logic       par_q;
  logic       stop2_q;

  assign last_stop      = tx_state_q == ST_STOP2 || (tx_state_q == ST_STOP1 && !stop2_q);
  assign fifo_out_ready = transmit_enable &&
                          (tx_state_q == ST_IDLE || (last_stop && bit_end)); // R16 R15
  assign load           = fifo_out_valid & fifo_out_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_q <= ST_IDLE;
      shift_q    <= '0;
      bit_cnt_q  <= '0;
      par_en_q   <= 1'b0;
      par_q      <= 1'b0;
      stop2_q    <= 1'b0;
    end else if (load) begin
      tx_state_q <= ST_START; // R16 R11
      shift_q    <= fifo_word; // R24
      bit_cnt_q  <= char_bits(frame_format.character_size_field) - 4'h1; // R09 R12
      par_en_q   <= frame_format.parity_mode_field[PARITY_ENABLE_POS]; // R14
      par_q      <= frame_parity(fifo_word, frame_format.character_size_field,
                                 frame_format.parity_mode_field[PARITY_ODD_POS]); // R13
      stop2_q    <= frame_format.stop_bit_count; // R12
    end else if (bit_end) begin
      unique case (tx_state_q)
        ST_IDLE: begin
          tx_state_q <= ST_IDLE;
        end
        ST_START: begin
          tx_state_q <= ST_DATA;
        end
        ST_DATA: begin
          if (bit_cnt_q == 4'h0) begin
            tx_state_q <= par_en_q ? ST_PARITY : ST_STOP1; // R10 R14
          end else begin
            shift_q   <= shift_q >> 1; // R10
            bit_cnt_q <= bit_cnt_q - 4'h1;
          end
        end
        ST_PARITY: begin
          tx_state_q <= ST_STOP1;
        end
        ST_STOP1: begin
          tx_state_q <= stop2_q ? ST_STOP2 : ST_IDLE; // R09
        end
        ST_STOP2: begin
          tx_state_q <= ST_IDLE;
        end
        default: begin
          tx_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Line driver: one cycle behind the state, so every bit keeps its full width
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_output_pin <= LINE_IDLE;
    end else begin
      unique case (tx_state_q)
        ST_START:  serial_output_pin <= LINE_START; // R09
        ST_DATA:   serial_output_pin <= shift_q[0]; // R10
        ST_PARITY: serial_output_pin <= par_q; // R14
        default:   serial_output_pin <= LINE_IDLE; // R11
      endcase
    end
  end

  // Pin ownership
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_output_pin_oe <= 1'b0;
      serial_clock_pin_oe  <= 1'b0;
    end else begin
      serial_output_pin_oe <= transmit_enable | busy; // R15
      serial_clock_pin_oe  <= master; // R05
    end
  end

  assign serial_clock_pin_out = sck_q;

  // Status flags: a set in the same cycle as a clear wins
  logic dre_set;
  logic txc_set;

  assign dre_set = load && fifo_level == ($clog2(FIFO_DEPTH)+1)'(1) && !push;
  assign txc_set = bit_end && last_stop && !fifo_out_valid;

  always_ff @(posedge clk) begin
    if (reset) begin
      buffer_empty_flag <= RESET_BUFFER_EMPTY;
    end else if (dre_set) begin
      buffer_empty_flag <= 1'b1; // R18
    end else if (push || buffer_empty_clear) begin
      buffer_empty_flag <= 1'b0; // R18
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      transmit_complete_flag <= RESET_COMPLETE;
    end else if (txc_set) begin
      transmit_complete_flag <= 1'b1; // R20
    end else if (transmit_complete_ack || transmit_complete_clear) begin
      transmit_complete_flag <= 1'b0; // R21
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      buffer_empty_irq      <= 1'b0;
      transmit_complete_irq <= 1'b0;
    end else begin
      buffer_empty_irq      <= buffer_empty_flag & buffer_empty_irq_enable &
                               global_irq_enable; // R19
      transmit_complete_irq <= transmit_complete_flag & transmit_complete_irq_enable &
                               global_irq_enable; // R22
    end
  end

  // Checking helpers
  logic [31:0] start_len_q;

  always_ff @(posedge clk) begin
    if (reset || tx_state_q != ST_START) begin
      start_len_q <= '0;
    end else begin
      start_len_q <= start_len_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  idle_line_high_a: assert property (tx_state_q == ST_IDLE |=> serial_output_pin) // R11
    else $error("line not high while idle");
  start_bit_low_a: assert property (tx_state_q == ST_START |=> !serial_output_pin) // R09
    else $error("start bit not low");
  stop_bits_high_a: assert property (last_stop |=> serial_output_pin) // R09
    else $error("stop bit not high");
  parity_value_a: assert property (tx_state_q == ST_PARITY |=> serial_output_pin == $past(par_q)) // R13
    else $error("parity bit wrong");
  parity_gate_a: assert property ($rose(tx_state_q == ST_PARITY) |-> par_en_q) // R14
    else $error("parity sent while disabled");
  second_stop_a: assert property (tx_state_q == ST_STOP2 |-> stop2_q) // R09
    else $error("second stop while one stop selected");
  async_bit_len_a: assert property (
      $fell(tx_state_q == ST_START) && !sync_mode && $stable(baud_divisor) |->
      start_len_q == (double_speed_enable ? OS_DOUBLE : OS_NORMAL) *
                     (32'(baud_divisor) + 32'h1)) // R02
    else $error("async bit length wrong");
  disable_hold_a: assert property (tx_state_q == ST_IDLE && !transmit_enable |=>
                                   tx_state_q == ST_IDLE) // R15
    else $error("frame started while disabled");
  master_clock_a: assert property (master && busy && baud_tick |=>
                                   serial_clock_pin_out != $past(serial_clock_pin_out)) // R04
    else $error("master clock missed a toggle");
  complete_set_a: assert property ($rose(transmit_complete_flag) |->
                                   $past(last_stop && bit_end && !fifo_out_valid)) // R20
    else $error("complete flag set early");
  empty_flag_a: assert property ($rose(buffer_empty_flag) |-> !fifo_out_valid) // R18
    else $error("empty flag set with data");
  empty_irq_a: assert property (!$past(reset) |-> buffer_empty_irq ==
      $past(buffer_empty_flag & buffer_empty_irq_enable & global_irq_enable)) // R19
    else $error("empty interrupt mismatch");
  complete_irq_a: assert property (!$past(reset) |-> transmit_complete_irq ==
      $past(transmit_complete_flag & transmit_complete_irq_enable & global_irq_enable)) // R22
    else $error("complete interrupt mismatch");

  parity_frame_c: cover property (tx_state_q == ST_PARITY ##[1:1000] tx_state_q == ST_STOP2);
  back_to_back_c: cover property (last_stop && bit_end && load);
  slave_frame_c: cover property (sync_mode && !master && txc_set);
endmodule // usart_clock_frame_transmitter

// ### tb/serial_peer_model.sv
// Purpose: Remote serial peer: frame receiver on the line and slave clock source
// Assumes: Bench sets bit length and format before each frame starts
// Notes:   Samples mid bit on the falling system edge, clear of the line flop updates
`timescale 1ns/1ps
module serial_peer_model (
  input  wire logic clk,
  input  wire logic line,
  input  wire logic rx_on,
  input  wire logic run_sck,
  input  int        bit_clks,
  input  int        nbits,
  input  wire logic par_en,
  output logic      sck,
  output logic [8:0] word,
  output logic      par,
  output logic      stop_ok,
  output int        frames
);
  int sck_cnt;

  // Ten clocks a half period keeps the clock at 1 MHz; it rests low while run_sck is clear
  initial begin
    sck = 1'b0;
    sck_cnt = 0;
    forever begin
      @(posedge clk);
      sck_cnt = run_sck ? sck_cnt + 1 : 0;
      if (!run_sck) begin
        sck <= 1'b0;
      end else if (sck_cnt == 10) begin
        sck <= ~sck;
        sck_cnt = 0;
      end
    end
  end

  initial begin
    frames = 0;
    par = 1'b0;
    stop_ok = 1'b0;
    forever begin
      @(negedge line iff rx_on);
      word = '0;
      repeat (bit_clks / 2) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(negedge clk);
        word[i] = line;
      end
      if (par_en) begin
        repeat (bit_clks) @(negedge clk);
        par = line;
      end
      repeat (bit_clks) @(negedge clk);
      stop_ok = line;
      frames++;
    end
  end
endmodule // serial_peer_model

// ### tb/tb_usart_clock_frame_transmitter.sv
// Purpose: Self-checking bench for the serial clock, frame and transmit block
// Assumes: Peer model decodes asynchronous frames; polarity one only in the master check
// Notes:   Inputs move on rising edges, outputs are sampled on falling edges
`timescale 1ns/1ps
module tb_usart_clock_frame_transmitter
  import usart_tx_pkg::*;
;
  logic          clk, reset, double_speed_enable, clock_master_select, clock_polarity;
  logic [1:0]    operating_mode_select;
  logic [7:0]    baud_divisor, serial_data_register;
  frame_format_t frame_format;
  logic          transmit_enable, transmit_ninth_bit, data_write, data_write_ready;
  logic          buffer_empty_irq_enable, transmit_complete_irq_enable, global_irq_enable;
  logic          serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe, peer_sck;
  logic          serial_output_pin, serial_output_pin_oe, tx_line, buffer_empty_flag;
  logic          transmit_complete_flag, buffer_empty_irq, transmit_complete_irq;
  logic          rx_on, run_sck, par_en, rx_par, rx_stop;
  logic [2:0]    clr;
  logic [8:0]    rx_word, ex;
  int            bit_clks, nbits, rx_frames, bad_count, checks_done, n, c;
  logic [2:0]    sz[4] = '{SIZE_5, SIZE_6, SIZE_7, SIZE_9};
  logic [1:0]    pm[4] = '{2'h2, 2'h3, 2'h1, 2'h3};
  int            nb[4] = '{5, 6, 7, 9};

  // Two-way clock pin: the master drives it, otherwise the peer does
  assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : peer_sck;
  // A released output pin is pulled up
  assign tx_line = serial_output_pin_oe ? serial_output_pin : 1'b1;

  usart_clock_frame_transmitter dut (.clk, .reset, .operating_mode_select,
    .double_speed_enable, .clock_master_select, .clock_polarity, .baud_divisor, .frame_format,
    .transmit_enable, .transmit_ninth_bit, .serial_data_register, .data_write, .data_write_ready,
    .buffer_empty_clear(clr[0]), .transmit_complete_clear(clr[1]), .transmit_complete_ack(clr[2]),
    .buffer_empty_irq_enable, .transmit_complete_irq_enable, .global_irq_enable,
    .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe, .serial_output_pin,
    .serial_output_pin_oe, .buffer_empty_flag, .transmit_complete_flag, .buffer_empty_irq,
    .transmit_complete_irq);

  serial_peer_model peer (.clk, .line(tx_line), .rx_on, .run_sck, .bit_clks, .nbits, .par_en,
    .sck(peer_sck), .word(rx_word), .par(rx_par), .stop_ok(rx_stop), .frames(rx_frames));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("[ERR] %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return tx_line;
      1: return serial_clock_pin_out;
      2: return serial_output_pin_oe;
      3: return peer_sck;
      default: return transmit_complete_flag;
    endcase
  endfunction

  // Counts falling edges until the chosen signal reaches the level
  task automatic wait_sig(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (pick(sel) !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > 9000) give_up("signal wait");
    end
  endtask

  task automatic wait_frames(input int target);
    int t;
    t = 0;
    while (rx_frames < target) begin
      @(negedge clk);
      t++;
      if (t > 9000) give_up("peer frame");
    end
  endtask

  task automatic wr(input logic [8:0] w);
    @(posedge clk);
    data_write <= 1'b1;
    {transmit_ninth_bit, serial_data_register} <= w;
    @(posedge clk);
    data_write <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= 3'h0;
  endtask

  initial begin
    reset = 1'b1;
    operating_mode_select = MODE_ASYNC;
    {double_speed_enable, clock_master_select, clock_polarity} = 3'h0;
    baud_divisor = 8'h00;
    frame_format = '{3'h3, 2'h0, 1'b0};
    {transmit_enable, transmit_ninth_bit, data_write} = 3'h0;
    serial_data_register = 8'h00;
    clr = 3'h0;
    {buffer_empty_irq_enable, transmit_complete_irq_enable, global_irq_enable} = 3'h0;
    {rx_on, run_sck, par_en} = 3'h4;
    bit_clks = 16;
    nbits = 8;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("reset flags", 9'h002, {buffer_empty_flag, transmit_complete_flag});
    chk("reset pins", 9'h00A, {tx_line, serial_output_pin_oe, data_write_ready, 1'b0});
    @(posedge clk);
    {transmit_enable, global_irq_enable} <= 2'h3;
    {buffer_empty_irq_enable, transmit_complete_irq_enable} <= 2'h3;
    wr(9'h0A5);
    wait_sig(0, 1'b0, c);
    wait_sig(0, 1'b1, c);
    chk("normal start clocks", 9'd16, 9'(c));
    wait_frames(1);
    chk("8N1 word", 9'h0A5, rx_word);
    chk("8N1 stop", 9'h001, rx_stop);
    wait_sig(4, 1'b1, c);
    @(negedge clk);
    chk("irqs", 9'h003, {buffer_empty_irq, transmit_complete_irq});
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (2) @(negedge clk);
    chk("irqs masked", 9'h000, {buffer_empty_irq, transmit_complete_irq});
    pulse(3'h4);
    @(negedge clk);
    chk("complete after ack", 9'h000, transmit_complete_flag);
    pulse(3'h1);
    @(negedge clk);
    chk("empty after clear", 9'h000, buffer_empty_flag);
    @(posedge clk);
    double_speed_enable <= 1'b1;
    baud_divisor <= 8'h02;
    bit_clks = 24;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      frame_format <= '{sz[k], pm[k], k[0]};
      nbits = nb[k];
      par_en = pm[k][1];
      ex = 9'h1B5 & ~(9'h1FF << nb[k]);
      n = rx_frames;
      wr(9'h1B5);
      wait_sig(0, 1'b0, c);
      wait_sig(0, 1'b1, c);
      chk("double start clocks", 9'd24, 9'(c));
      wait_frames(n + 1);
      chk("format word", ex, rx_word);
      if (par_en) chk("parity", 9'(^ex ^ pm[k][0]), rx_par);
      chk("format stop", 9'h001, rx_stop);
      wait_sig(4, 1'b1, c);
      pulse(3'h4);
    end
    @(posedge clk);
    transmit_enable <= 1'b0;
    frame_format <= '{3'h3, 2'h0, 1'b0};
    {nbits, par_en} = {32'd8, 1'b0};
    for (int k = 0; k < 5; k++) wr(9'(8'h30 + k));
    @(negedge clk);
    chk("full", 9'h000, {data_write_ready, buffer_empty_flag});
    n = rx_frames;
    @(posedge clk);
    transmit_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wait_frames(n + k + 1);
      chk("queued word", 9'(8'h30 + k), rx_word);
    end
    chk("complete while queued", 9'h000, transmit_complete_flag);
    wait_sig(4, 1'b1, c);
    chk("refused fifth", 9'(n + 4), 9'(rx_frames));
    chk("drained", 9'h001, buffer_empty_flag);
    pulse(3'h2);
    @(negedge clk);
    chk("complete after clear", 9'h000, transmit_complete_flag);
    n = rx_frames;
    wr(9'h0C3);
    wr(9'h03C);
    wait_sig(0, 1'b0, c);
    @(posedge clk);
    transmit_enable <= 1'b0;
    wait_frames(n + 1);
    chk("late disable word", 9'h0C3, rx_word);
    wait_sig(2, 1'b0, c);
    repeat (300) @(negedge clk);
    chk("nothing restarted", 9'(n + 1), 9'(rx_frames));
    chk("word kept", 9'h000, buffer_empty_flag);
    rx_on = 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      operating_mode_select <= k ? MODE_SPI : MODE_SYNC;
      {clock_master_select, transmit_enable} <= 2'h3;
      clock_polarity <= k[0];
      if (k == 1) wr(9'h055);
      wait_sig(1, !k[0], c);
      wait_sig(1, k[0], c);
      chk("master half period", 9'd3, 9'(c));
      chk("master pin drive", 9'h001, serial_clock_pin_oe);
      wait_sig(4, 1'b1, c);
      pulse(3'h4);
    end
    @(posedge clk);
    clock_master_select <= 1'b0;
    clock_polarity <= 1'b0;
    wr(9'h055);
    @(negedge clk);
    chk("slave pin released", 9'h000, serial_clock_pin_oe);
    run_sck = 1'b1;
    wait_sig(0, 1'b0, c);
    wait_sig(3, 1'b0, c);
    wait_sig(3, 1'b1, c);
    wait_sig(0, 1'b1, c);
    chk("slave edge to line", 9'd4, 9'(c));
    wait_sig(4, 1'b1, c);
    run_sck = 1'b0;
    tally_and_finish();
  end
endmodule // tb_usart_clock_frame_transmitter
